// ---- logic/sees_slave.sv ----
// two-wire slave front end for a 256 by 8 eeprom array
// Notes on behaviour
// - 256 bytes of 8 bits, 8-bit address
// - protocol stepped by serial clock edges and by start and stop conditions
// - start, seven address bits, then direction bit
// - acknowledge a matching start instruction
// - chip-select pins form part of address
// - byte write stores at supplied address
// - multibyte mode: up to four bytes, one cycle
// - page mode: one to eight bytes, one cycle
// - current read uses pointer, which holds last address plus one
// - random read returns supplied address byte
// - sequential read continues while master acknowledges
// - programming cycle ends within 10 ms
// - multibyte across rows takes the same single time
// - every data bit clocked by serial clock
// - data line driven open-drain, low only
// - chip selects are low address bits
// - last bit one reads, zero writes
// - mode pin low selects page mode
// - page mode increments low three bits only
`timescale 1ns/100ps
module sees_slave
  import sees_pkg::*;
#(
  parameter int TWR_CYCLES = SEES_TWR_CYC
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic chip_select_bit_zero,
  input wire logic chip_select_bit_one,
  input wire logic chip_select_bit_two,
  input wire logic mode_sel,
  output logic busy
);
  typedef struct packed {
    logic [1:0] scl_s;
    logic [1:0] sda_s;
    logic [3:0] cs_m;
    logic [3:0] cs_s;
    logic scl_p;
    logic sda_p;
    sees_state_t st;
    sees_state_t nxt;
    logic [3:0] bitc;
    logic [7:0] sh;
    logic rd;
    logic [7:0] ptr;
    logic [7:0] base;
    logic [3:0] cnt;
    logic page;
    logic [31:0] tmr;
    logic sda_oe;
    logic busy;
  } sees_regs_t;

  logic [7:0] mem [SEES_DEPTH];
  logic [7:0] wbuf [SEES_PAGE_MAX];
  sees_regs_t q, d;
  logic scl, sda, rise, fall, start_c, stop_c;
  logic [7:0] rdat;

  assign scl = q.scl_s[1];
  assign sda = q.sda_s[1];
  // serial clock edges found by sampling
  assign rise = scl & ~q.scl_p;
  assign fall = ~scl & q.scl_p;
  assign start_c = scl & q.scl_p & q.sda_p & ~sda;
  assign stop_c = scl & q.scl_p & ~q.sda_p & sda;
  assign rdat = mem[q.ptr];

  always_comb begin
    d = q;
    d.scl_s = {q.scl_s[0], scl_in};
    d.sda_s = {q.sda_s[0], sda_in};
    d.cs_m = {chip_select_bit_two, chip_select_bit_one, chip_select_bit_zero, mode_sel};
    d.cs_s = q.cs_m;
    d.scl_p = scl;
    d.sda_p = sda;
    if (q.st == SEES_PROG) begin
      d.sda_oe = 1'b0;
      // self-timed end; one bound covers both row cases
      if (q.tmr == 32'h0000_0001) begin
        d.st = SEES_IDLE;
        d.busy = 1'b0;
      end
      d.tmr = q.tmr - 32'h0000_0001;
    end else if (start_c) begin
      d.st = SEES_DEV;
      d.bitc = 4'h0;
      d.sda_oe = 1'b0;
    end else if (stop_c) begin
      d.sda_oe = 1'b0;
      // stop after written data starts programming
      if (q.st == SEES_WDAT && q.cnt != 4'h0) begin
        d.st = SEES_PROG;
        d.busy = 1'b1;
        d.tmr = TWR_CYCLES;
      end else begin
        d.st = SEES_IDLE;
      end
    end else begin
      unique case (q.st)
        SEES_IDLE, SEES_PROG: ;
        SEES_DEV, SEES_WADR, SEES_WDAT: begin
          // bits taken on rising edges only
          if (rise) begin
            d.sh = {q.sh[6:0], sda};
            d.bitc = q.bitc + 4'h1;
          end
          if (fall && q.bitc == 4'h8) begin
            d.bitc = 4'h0;
            d.nxt = SEES_IDLE;
            d.st = SEES_ACK;
            if (q.st == SEES_DEV) begin
              // match type code and chip selects
              if (q.sh[7:1] == {SEES_TYPE_CODE, q.cs_s[3:1]}) begin
                d.sda_oe = 1'b1;
                d.rd = q.sh[0];
                d.nxt = q.sh[0] ? SEES_RDAT : SEES_WADR;
              end else begin
                d.st = SEES_IDLE;
              end
            end else if (q.st == SEES_WADR) begin
              d.sda_oe = 1'b1;
              // random read starts at this address
              d.ptr = q.sh;
              d.base = q.sh;
              d.cnt = 4'h0;
              d.page = ~q.cs_s[0];
              d.nxt = SEES_WDAT;
            end else begin
              d.sda_oe = 1'b1;
              d.nxt = SEES_WDAT;
              if (q.page) begin
                if (q.cnt < 4'(SEES_PAGE_MAX))
                  d.cnt = q.cnt + 4'h1;
                d.ptr = {q.ptr[7:3], q.ptr[2:0] + 3'h1};
              end else begin
                if (q.cnt < 4'(SEES_MULTI_MAX))
                  d.cnt = q.cnt + 4'h1;
                d.ptr = q.ptr + 8'h01;
              end
            end
          end
        end
        SEES_ACK: begin
          if (fall) begin
            d.st = q.nxt;
            d.bitc = 4'h0;
            d.sda_oe = (q.nxt == SEES_RDAT) ? ~rdat[7] : 1'b0;
            d.sh = rdat;
          end
        end
        SEES_RDAT: begin
          if (fall) begin
            d.bitc = q.bitc + 4'h1;
            if (q.bitc == 4'h7) begin
              d.sda_oe = 1'b0;
              d.st = SEES_RACK;
              // pointer now last byte read plus one
              d.ptr = q.ptr + 8'h01;
            end else begin
              d.sh = {q.sh[6:0], 1'b0};
              d.sda_oe = ~q.sh[6];
            end
          end
        end
        SEES_RACK: begin
          if (rise) begin
            if (!sda) begin
              d.nxt = SEES_RDAT;
              d.st = SEES_ACK;
            end else begin
              d.st = SEES_IDLE;
            end
          end
        end
      endcase
    end
  end

  // write capture and commit; first byte at supplied address
  always_ff @(posedge clock) begin
    if (q.st == SEES_WDAT && fall && q.bitc == 4'h8 && !q.page && q.cnt < 4'(SEES_MULTI_MAX))
      wbuf[q.cnt[2:0]] <= q.sh;
    if (q.st == SEES_WDAT && fall && q.bitc == 4'h8 && q.page)
      wbuf[q.ptr[2:0]] <= q.sh;
    if (q.st == SEES_PROG && q.tmr == 32'h0000_0001) begin
      for (int i = 0; i < SEES_PAGE_MAX; i++) begin
        if (q.page && i < int'(q.cnt))
          mem[{q.base[7:3], 3'(q.base[2:0] + 3'(i))}] <= wbuf[3'(q.base[2:0] + 3'(i))];
        else if (!q.page && i < int'(q.cnt))
          mem[8'(q.base + 8'(i))] <= wbuf[i];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      q <= '0;
      q.scl_s <= 2'h3;
      q.sda_s <= 2'h3;
      q.scl_p <= 1'b1;
      q.sda_p <= 1'b1;
      q.st <= SEES_IDLE;
      q.nxt <= SEES_IDLE;
      q.ptr <= SEES_ADDR_RESET;
    end else begin
      q <= d;
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe = q.sda_oe;
  assign busy = q.busy;

  property p_quiet_prog;
    @(posedge clock) disable iff (sys_rst) q.st == SEES_PROG |-> !sda_oe;
  endproperty
  a_quiet_prog: assert property (p_quiet_prog) else $error("drove data while programming");
  property p_dev_ack;
    @(posedge clock) disable iff (sys_rst)
      q.st == SEES_DEV && fall && q.bitc == 4'h8 && q.sh[7:1] == {SEES_TYPE_CODE, q.cs_s[3:1]}
      |=> sda_oe && q.st == SEES_ACK;
  endproperty
  a_dev_ack: assert property (p_dev_ack) else $error("no ack on match");
  property p_no_ack_mismatch;
    @(posedge clock) disable iff (sys_rst)
      q.st == SEES_DEV && fall && q.bitc == 4'h8 && q.sh[7:1] != {SEES_TYPE_CODE, q.cs_s[3:1]}
      |=> !sda_oe && q.st == SEES_IDLE;
  endproperty
  a_no_ack_mismatch: assert property (p_no_ack_mismatch) else $error("ack on mismatch");
  property p_stop_prog;
    @(posedge clock) disable iff (sys_rst)
      stop_c && q.st == SEES_WDAT && q.cnt != 4'h0 |=> busy ##1 busy;
  endproperty
  a_stop_prog: assert property (p_stop_prog) else $error("stop did not start programming");
  property p_prog_len;
    @(posedge clock) disable iff (sys_rst) $rose(busy) |-> q.tmr == TWR_CYCLES;
  endproperty
  a_prog_len: assert property (p_prog_len) else $error("programming time wrong");
  property p_page_wrap;
    @(posedge clock) disable iff (sys_rst)
      q.st == SEES_WDAT && q.page && fall && q.bitc == 4'h8 |=> q.ptr[7:3] == $past(q.ptr[7:3]);
  endproperty
  a_page_wrap: assert property (p_page_wrap) else $error("page upper bits moved");
  property p_multi_max;
    @(posedge clock) disable iff (sys_rst) !q.page |-> q.cnt <= 4'(SEES_MULTI_MAX);
  endproperty
  a_multi_max: assert property (p_multi_max) else $error("multibyte count over four");
  property p_page_max;
    @(posedge clock) disable iff (sys_rst) q.cnt <= 4'(SEES_PAGE_MAX);
  endproperty
  a_page_max: assert property (p_page_max) else $error("page count over eight");
  property p_seq_adv;
    @(posedge clock) disable iff (sys_rst)
      q.st == SEES_RDAT && fall && q.bitc == 4'h7 |=> q.ptr == $past(q.ptr) + 8'h01;
  endproperty
  a_seq_adv: assert property (p_seq_adv) else $error("sequential read did not advance");
  c_write: cover property (@(posedge clock) disable iff (sys_rst) $rose(busy));
  c_read: cover property (@(posedge clock) disable iff (sys_rst) q.st == SEES_RACK && rise && !sda);
  c_page: cover property (@(posedge clock) disable iff (sys_rst) q.page && q.cnt == 4'h8);
endmodule

// ---- logic/sees_pkg.sv ----
// constants and types for the two-wire eeprom slave
package sees_pkg;
  localparam int SEES_DEPTH = 256;
  localparam int SEES_WIDTH = 8;
  // upper four address bits: device-type code, value arbitrary
  localparam logic [3:0] SEES_TYPE_CODE = 4'h5;
  localparam int SEES_MULTI_MAX = 4;
  localparam int SEES_PAGE_MAX = 8;
  localparam int SEES_CLK_MHZ = 100;
  localparam int SEES_TWR_MS = 10;
  localparam int SEES_TWR_CYC = SEES_TWR_MS * 1000 * SEES_CLK_MHZ;
  localparam logic [7:0] SEES_ADDR_RESET = 8'h00;
  typedef enum logic [2:0] {
    SEES_IDLE, SEES_DEV, SEES_WADR, SEES_WDAT, SEES_RDAT, SEES_RACK, SEES_ACK, SEES_PROG
  } sees_state_t;
endpackage

// ---- bench/sees_bus_mst.sv ----
// two-wire bus master model: drives serial clock and data
`timescale 1ns/100ps
module sees_bus_mst #(
  parameter int HALF = 8
) (
  input wire logic clock,
  input wire logic sda_line,
  output logic scl,
  output logic sda
);
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic start_cond();
    sda <= 1'b1;
    wait_clk(HALF);
    scl <= 1'b1;
    wait_clk(HALF);
    sda <= 1'b0;
    wait_clk(HALF);
    scl <= 1'b0;
    wait_clk(1);
  endtask
  task automatic stop_cond();
    sda <= 1'b0;
    wait_clk(HALF);
    scl <= 1'b1;
    wait_clk(HALF);
    sda <= 1'b1;
    wait_clk(HALF);
  endtask
  // data moves only while clock low
  task automatic clock_bit(input logic b, output logic seen);
    sda <= b;
    wait_clk(HALF);
    scl <= 1'b1;
    wait_clk(HALF);
    @(negedge clock);
    seen = sda_line;
    @(posedge clock);
    scl <= 1'b0;
    wait_clk(1);
  endtask
  task automatic send_byte(input logic [7:0] b, output logic acked);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clock_bit(b[i], s);
    end
    clock_bit(1'b1, s);
    acked = ~s;
  endtask
  task automatic recv_byte(input logic ack_it, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clock_bit(1'b1, s);
      b[i] = s;
    end
    clock_bit(~ack_it, s);
  endtask
endmodule

// ---- bench/tb_sees_slave.sv ----
// self-checking bench for the two-wire eeprom slave
`timescale 1ns/100ps
module tb_sees_slave import sees_pkg::*;;
  localparam int TWR = 400;
  logic clock, sys_rst, mode_sel, scl, sda, sda_out, sda_oe, busy, sda_line;
  logic [2:0] cs;
  logic [7:0] expq [$];
  int error_cnt = 0, checks_done = 0, cyc = 0;
  // pull-up: released line reads high
  assign sda_line = sda & ~(sda_oe & ~sda_out);
  sees_slave #(.TWR_CYCLES(TWR)) sees_slave_inst (.clock(clock), .sys_rst(sys_rst), .scl_in(scl),
    .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .chip_select_bit_zero(cs[0]),
    .chip_select_bit_one(cs[1]), .chip_select_bit_two(cs[2]), .mode_sel(mode_sel), .busy(busy));
  sees_bus_mst sees_bus_mst_inst (.clock(clock), .sda_line(sda_line), .scl(scl), .sda(sda));
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic addr_byte(input logic [2:0] sel, input logic rd, input logic ack, input string what);
    logic a;
    sees_bus_mst_inst.send_byte({SEES_TYPE_CODE, sel, rd}, a);
    check(what, {7'h00, ack}, {7'h00, a});
  endtask
  task automatic write_seq(input logic [7:0] adr, input int n, input logic [7:0] d0);
    logic a;
    int t0;
    sees_bus_mst_inst.start_cond();
    addr_byte(cs, 1'b0, 1'b1, "write address ack");
    sees_bus_mst_inst.send_byte(adr, a);
    check("word address ack", 8'h01, {7'h00, a});
    for (int i = 0; i < n; i++) begin
      sees_bus_mst_inst.send_byte(d0 + 8'(i), a);
      check("data ack", 8'h01, {7'h00, a});
    end
    sees_bus_mst_inst.stop_cond();
    t0 = cyc;
    check("busy after stop", 8'h01, {7'h00, busy});
    sees_bus_mst_inst.start_cond();
    addr_byte(cs, 1'b1, 1'b0, "ack while busy");
    sees_bus_mst_inst.stop_cond();
    for (int k = 0; k < TWR && busy !== 1'b0; k++) @(posedge clock);
    check("busy within bound", 8'h01, {7'h00, busy === 1'b0 && cyc - t0 <= TWR});
  endtask
  task automatic read_seq(input logic rnd, input logic [7:0] adr);
    logic a;
    logic [7:0] b;
    int n;
    n = expq.size();
    if (rnd) begin
      sees_bus_mst_inst.start_cond();
      addr_byte(cs, 1'b0, 1'b1, "dummy write ack");
      sees_bus_mst_inst.send_byte(adr, a);
      check("read word address ack", 8'h01, {7'h00, a});
    end
    sees_bus_mst_inst.start_cond();
    addr_byte(cs, 1'b1, 1'b1, "read address ack");
    for (int i = 0; i < n; i++) begin
      sees_bus_mst_inst.recv_byte(i < n - 1, b);
      check("read byte", expq.pop_front(), b);
    end
    sees_bus_mst_inst.stop_cond();
  endtask
  task automatic sc_byte_write();
    mode_sel <= 1'b1;
    write_seq(8'h10, 1, 8'h3c);
    expq = '{8'h3c};
    read_seq(1'b1, 8'h10);
  endtask
  task automatic sc_multi();
    write_seq(8'h47, 4, 8'h61);
    expq = '{8'h61, 8'h62, 8'h63, 8'h64};
    read_seq(1'b1, 8'h47);
    expq = '{8'h61};
    read_seq(1'b1, 8'h47);
    expq = '{8'h62};
    read_seq(1'b0, 8'h00);
  endtask
  task automatic sc_page();
    mode_sel <= 1'b0;
    // nine bytes from 0x26 wrap inside row 0x20
    write_seq(8'h26, 9, 8'ha0);
    expq = '{8'ha2, 8'ha3, 8'ha4, 8'ha5, 8'ha6, 8'ha7, 8'ha8, 8'ha1};
    read_seq(1'b1, 8'h20);
  endtask
  task automatic sc_select();
    sees_bus_mst_inst.start_cond();
    addr_byte(cs ^ 3'b100, 1'b1, 1'b0, "foreign address ack");
    sees_bus_mst_inst.stop_cond();
    cs <= 3'b010;
    sees_bus_mst_inst.wait_clk(4);
    expq = '{8'ha2};
    read_seq(1'b1, 8'h20);
  endtask
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  initial begin
    sys_rst = 1'b1;
    cs = 3'b101;
    mode_sel = 1'b1;
    repeat (5) @(posedge clock);
    sys_rst <= 1'b0;
    sees_bus_mst_inst.wait_clk(8);
    sc_byte_write();
    sc_multi();
    sc_page();
    sc_select();
    tally_and_finish();
  end
endmodule
